// ### shared/bfs_pkg.sv
// Constants, timing and register map of the ballast fault supervisor
package bfs_pkg;
	localparam int CLK_NS = 100;
	localparam int T_INV_HI_NS = 400;
	localparam int T_INV_LO_NS = 250;
	localparam int T_BOOST_NS = 260;
	localparam int T_OV_US = 5;
	localparam int T_OV_EARLY_US = 10;
	localparam int T_OPEN_US = 1;
	localparam int T_UV_US = 80;
	localparam int T_PEAK_US = 610;
	localparam int T_FIL_MS = 1;
	localparam int T_SEV_US = 610;
	localparam int T_SEV_TICK_US = 40;
	localparam int T_EOL_TICK_MS = 4;
	localparam int T_EOL_MS = 500;
	localparam int T_IGN_MS = 235;
	localparam int T_RES_HALF_US = 500;
	localparam int N_INV_HI = (T_INV_HI_NS + CLK_NS - 1) / CLK_NS;
	localparam int N_INV_LO = (T_INV_LO_NS + CLK_NS - 1) / CLK_NS;
	localparam int N_BOOST = (T_BOOST_NS + CLK_NS - 1) / CLK_NS;
	localparam int N_OV = T_OV_US * 1000 / CLK_NS;
	localparam int N_OV_EARLY = T_OV_EARLY_US * 1000 / CLK_NS;
	localparam int N_OPEN = T_OPEN_US * 1000 / CLK_NS;
	localparam int N_UV = T_UV_US * 1000 / CLK_NS;
	localparam int N_PEAK = T_PEAK_US * 1000 / CLK_NS;
	localparam int N_FIL = T_FIL_MS * 1000000 / CLK_NS;
	localparam int N_SEV_TICK = T_SEV_TICK_US * 1000 / CLK_NS;
	localparam int N_EOL_TICK = T_EOL_TICK_MS * 1000000 / CLK_NS;
	localparam int N_IGN = T_IGN_MS * 1000000 / CLK_NS;
	localparam int N_RES_HALF = T_RES_HALF_US * 1000 / CLK_NS;
	localparam int SEV_LIM = (T_SEV_US + T_SEV_TICK_US - 1) / T_SEV_TICK_US;
	localparam int EOL_LIM = T_EOL_MS / T_EOL_TICK_MS;
	localparam int SETTLE_CYCLES = 32;
	// Synchronised pin indices
	localparam int S_INV_HI = 0, S_INV_LO = 1, S_BOOST = 2, S_OV = 3, S_REC = 4;
	localparam int S_UV = 5, S_OPEN = 6, S_PEAK = 7, S_ASYM = 8, S_RES_REF = 9;
	localparam int S_RES_HI = 10, S_RES_LO = 11, S_RES_OPEN = 12, S_LVS_LOW = 13;
	localparam int S_SUP_OK = 14, S_SUP_START = 15, NS = 16;
	// Duration qualifier indices
	localparam int Q_INV_HI = 0, Q_INV_LO = 1, Q_BOOST = 2, Q_OV = 3, Q_OPEN = 4;
	localparam int Q_UV = 5, Q_PEAK = 6, Q_FIL_LS = 7, Q_FIL_HS = 8, NQ = 9;
	// Register map, data in low bits
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CAUSE = 8'h08;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam int CTRL_EN_BIT = 0;
	localparam int C_INV = 0, C_INTEG = 1, C_SEV = 2, C_IGN = 3, C_PEAK = 4, NC = 5;
	typedef enum logic [7:0] {
		PH_LOCKOUT = 8'h01,
		PH_MONITOR = 8'h02,
		PH_SOFTSTART = 8'h04,
		PH_PREHEAT = 8'h08,
		PH_IGNITION = 8'h10,
		PH_PRERUN = 8'h20,
		PH_RUN = 8'h40,
		PH_FAULT = 8'h80
	} bfs_phase_t;
endpackage : bfs_pkg

// ### sim/bfs_far_side.sv
// Far-side model: supply comparators, half-bridge gate timing, restart-sense level
`timescale 1ns/10ps
module bfs_far_side (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_gate_enable,
	input wire logic i_supply_cut,
	input wire logic [1:0] i_cap_mode,
	output logic o_supply_ok,
	output logic o_supply_start,
	output logic o_low_side_gate,
	output logic o_high_side_gate,
	output logic o_res_above_ref
);
	logic [3:0] cnt_reg;
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cnt_reg <= 4'h0;
		else
			cnt_reg <= cnt_reg + 4'h1;
	end
	// Gates alternate with dead time, only while the drives are allowed
	assign o_low_side_gate = i_gate_enable && (cnt_reg < 4'h6);
	assign o_high_side_gate = i_gate_enable && (cnt_reg > 4'h7) && (cnt_reg < 4'he);
	// Mode 0: low before low-side turn-on, high before high-side turn-on: clean switching
	// Mode 1 holds the sense high (slight capacitive), mode 2 holds it low (severe)
	assign o_res_above_ref = (i_cap_mode == 2'h1)
		|| ((i_cap_mode == 2'h0) && (cnt_reg > 4'h1) && (cnt_reg < 4'hb));
	assign o_supply_ok = !i_supply_cut;
	assign o_supply_start = !i_supply_cut;
endmodule : bfs_far_side

// ### sim/bfs_supervisor_tb_top.sv
// Testbench for the ballast fault supervisor
`timescale 1ns/10ps
module bfs_supervisor_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [12:0] fl = 13'h0410;
	logic step = 1'b0;
	logic run_freq = 1'b0;
	logic cut = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [7:0] ph;
	logic gate_en, blk, pend, fstep, low_pw, flt, dis, s_ok, s_st, lsg, hsg, aref;
	logic rtk;
	logic lsg_q = 1'b0;
	logic [1:0] capm = 2'h0;
	logic prev = 1'b0;
	int n = 0;
	int miscompares = 0;
	int checks_done = 0;
	always #50 clk = ~clk;
	bfs_far_side far (.i_core_clk(clk), .i_rst_n(rst_n), .i_gate_enable(gate_en),
		.i_supply_cut(cut), .i_cap_mode(capm), .o_supply_ok(s_ok), .o_supply_start(s_st),
		.o_low_side_gate(lsg), .o_high_side_gate(hsg), .o_res_above_ref(aref));
	bfs_supervisor #(.PEAK_CYC(20), .FIL_CYC(20), .EOL_TICK_CYC(8), .IGN_CYC(200),
		.RES_HALF_CYC(4)) uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_inv_cur_hi(fl[0]),
		.i_inv_cur_lo(fl[1]), .i_boost_cur_over(fl[2]), .i_bus_over(fl[3]),
		.i_bus_recovered(fl[4]), .i_bus_under(fl[5]), .i_bus_open(fl[6]),
		.i_lamp_peak(fl[7]), .i_lamp_asym(fl[8]), .i_res_above_ref(aref),
		.i_res_above_hi(fl[9]), .i_res_below_lo(fl[10]), .i_res_open_fil(fl[11]),
		.i_lamp_sense_low(fl[12]), .i_supply_ok(s_ok), .i_supply_start(s_st),
		.i_low_side_gate(lsg), .i_high_side_gate(hsg), .i_phase_step(step),
		.i_run_freq_reached(run_freq), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .o_gate_enable(gate_en), .o_boost_block(blk),
		.o_boost_pulse_end(pend), .o_freq_step_up(fstep), .o_ref_track(rtk),
		.o_res_discharge(dis), .o_low_power(low_pw), .o_fault_latched(flt), .o_phase(ph));
	// ****
	// Helpers
	// ****
	always @(posedge clk)
	begin
		if (dis && !prev)
			n++;
		prev = dis;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
			begin
				miscompares++;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		chk(rdata, e);
	endtask : rd_chk
	task automatic step_to(input logic [7:0] p);
		for (int i = 0; i < 40 && ph !== p; i++)
		begin
			step <= 1'b1;
			@(posedge clk);
			step <= 1'b0;
			cyc(8);
		end
		chk(32'(ph), 32'(p));
	endtask : step_to
	task automatic recycle;
		cut <= 1'b1;
		cyc(10);
		cut <= 1'b0;
		cyc(4);
	endtask : recycle
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		#(100 * 30000);
		miscompares++;
		tally_and_finish();
	end
	// ****
	// Scenarios
	// ****
	initial
	begin
		cyc(2);
		rst_n <= 1'b1;
		chk(32'(ph), 32'h01);
		chk(32'({low_pw, gate_en}), 32'h2);
		rd_chk(8'h00, 32'h1);
		wr_reg(8'h00, 32'h0);
		wr_reg(8'h0c, 32'hffff_ffff);
		rd_chk(8'h0c, 32'h0);
		cyc(40);
		chk(32'(ph), 32'h01);
		wr_reg(8'h00, 32'h1);
		step_to(8'h04);
		fl[2] <= 1'b1;
		cyc(10);
		chk(32'(pend), 32'h1);
		fl[2] <= 1'b0;
		fl[0] <= 1'b1;
		cyc(3);
		fl[0] <= 1'b0;
		cyc(10);
		chk(32'(ph), 32'h04);
		n = 0;
		fl[0] <= 1'b1;
		cyc(12);
		chk(32'({flt, low_pw, gate_en, ph}), 32'h680);
		fl[0] <= 1'b0;
		fl[9] <= 1'b1;
		fl[10] <= 1'b0;
		rd_chk(8'h08, 32'h1);
		cyc(400);
		chk(n, 32);
		chk(32'(ph), 32'h80);
		fl[9] <= 1'b0;
		fl[10] <= 1'b1;
		cyc(10);
		chk(32'(ph), 32'h02);
		fl[12] <= 1'b1;
		cyc(30);
		step <= 1'b1;
		@(posedge clk);
		step <= 1'b0;
		cyc(2);
		chk(32'(ph), 32'h02);
		fl[12] <= 1'b0;
		step_to(8'h10);
		n = 0;
		fl[1] <= 1'b1;
		repeat (15)
		begin
			@(posedge clk);
			n += fstep;
		end
		fl[1] <= 1'b0;
		chk(32'(n > 0), 32'h1);
		cyc(220);
		chk(32'(ph), 32'h80);
		rd_chk(8'h08, 32'h8);
		cut <= 1'b1;
		cyc(8);
		chk(32'({flt, ph}), 32'h01);
		cut <= 1'b0;
		rd_chk(8'h08, 32'h0);
		step_to(8'h04);
		fl[6] <= 1'b1;
		cyc(20);
		chk(32'({flt, gate_en, ph}), 32'h01);
		fl[6] <= 1'b0;
		recycle();
		step_to(8'h08);
		capm <= 2'h2;
		cyc(5990);
		chk(32'(ph), 32'h08);
		cyc(500);
		chk(32'(ph), 32'h80);
		rd_chk(8'h08, 32'h4);
		capm <= 2'h0;
		recycle();
		run_freq <= 1'b1;
		step_to(8'h40);
		repeat (16)
		begin
			lsg_q = lsg;
			@(posedge clk);
			chk(32'(rtk), 32'(lsg_q));
		end
		fl[5] <= 1'b1;
		cyc(810);
		chk(32'({flt, gate_en, ph}), 32'h001);
		rd_chk(8'h04, 32'h201);
		fl[5] <= 1'b0;
		recycle();
		step_to(8'h40);
		fl[8] <= 1'b1;
		cyc(990);
		chk(32'(ph), 32'h40);
		cyc(30);
		chk(32'(ph), 32'h80);
		rd_chk(8'h08, 32'h2);
		fl[8] <= 1'b0;
		recycle();
		step_to(8'h40);
		capm <= 2'h1;
		cyc(1050);
		chk(32'(ph), 32'h80);
		rd_chk(8'h08, 32'h2);
		capm <= 2'h0;
		recycle();
		step_to(8'h40);
		fl[7] <= 1'b1;
		cyc(35);
		chk(32'(ph), 32'h80);
		rd_chk(8'h08, 32'h10);
		fl[7] <= 1'b0;
		run_freq <= 1'b0;
		recycle();
		step_to(8'h04);
		fl[3] <= 1'b1;
		cyc(10);
		chk(32'({flt, gate_en, ph}), 32'h001);
		fl[3] <= 1'b0;
		recycle();
		step_to(8'h04);
		cyc(110);
		fl[3] <= 1'b1;
		fl[4] <= 1'b0;
		cyc(60);
		chk(32'(blk), 32'h1);
		fl[3] <= 1'b0;
		cyc(10);
		chk(32'(blk), 32'h1);
		fl[4] <= 1'b1;
		cyc(10);
		chk(32'(blk), 32'h0);
		tally_and_finish();
	end
endmodule : bfs_supervisor_tb_top

// ### src/bfs_supervisor.sv
// Fault supervisor: flag qualification, phase machine, fault latch and registers
`timescale 1ns/10ps
module bfs_supervisor #(
	parameter int PEAK_CYC = bfs_pkg::N_PEAK,
	parameter int FIL_CYC = bfs_pkg::N_FIL,
	parameter int EOL_TICK_CYC = bfs_pkg::N_EOL_TICK,
	parameter int IGN_CYC = bfs_pkg::N_IGN,
	parameter int RES_HALF_CYC = bfs_pkg::N_RES_HALF
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_inv_cur_hi,
	input wire logic i_inv_cur_lo,
	input wire logic i_boost_cur_over,
	input wire logic i_bus_over,
	input wire logic i_bus_recovered,
	input wire logic i_bus_under,
	input wire logic i_bus_open,
	input wire logic i_lamp_peak,
	input wire logic i_lamp_asym,
	input wire logic i_res_above_ref,
	input wire logic i_res_above_hi,
	input wire logic i_res_below_lo,
	input wire logic i_res_open_fil,
	input wire logic i_lamp_sense_low,
	input wire logic i_supply_ok,
	input wire logic i_supply_start,
	input wire logic i_low_side_gate,
	input wire logic i_high_side_gate,
	input wire logic i_phase_step,
	input wire logic i_run_freq_reached,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_gate_enable,
	output logic o_boost_block,
	output logic o_boost_pulse_end,
	output logic o_freq_step_up,
	output logic o_ref_track,
	output logic o_res_discharge,
	output logic o_low_power,
	output logic o_fault_latched,
	output logic [7:0] o_phase
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [bfs_pkg::NS-1:0] pins, s1_reg, s2_reg, s3_reg, cln_reg;
	assign pins = {i_supply_start, i_supply_ok, i_lamp_sense_low, i_res_open_fil,
		i_res_below_lo, i_res_above_hi, i_res_above_ref, i_lamp_asym, i_lamp_peak,
		i_bus_open, i_bus_under, i_bus_recovered, i_bus_over, i_boost_cur_over,
		i_inv_cur_lo, i_inv_cur_hi};

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			cln_reg <= '0;
		end
		else
		begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// A change counts once stages two and three agree
			cln_reg <= (cln_reg & (s2_reg ^ s3_reg)) | (s3_reg & ~(s2_reg ^ s3_reg));
		end
	end

	// ****************************************
	// Phase decode
	// ****************************************
	bfs_pkg::bfs_phase_t phase_reg, phase_next;
	logic active, sup_ok, run, ign;
	assign sup_ok = cln_reg[bfs_pkg::S_SUP_OK];
	assign run = (phase_reg == bfs_pkg::PH_RUN);
	assign ign = (phase_reg == bfs_pkg::PH_IGNITION);
	assign active = (phase_reg == bfs_pkg::PH_SOFTSTART) || (phase_reg == bfs_pkg::PH_PREHEAT)
		|| ign || (phase_reg == bfs_pkg::PH_PRERUN) || run;

	// ****************************************
	// Duration qualifiers
	// ****************************************
	localparam logic [13:0] LIM_SHORT [0:5] = '{14'(bfs_pkg::N_INV_HI),
		14'(bfs_pkg::N_INV_LO), 14'(bfs_pkg::N_BOOST), 14'(bfs_pkg::N_OV),
		14'(bfs_pkg::N_OPEN), 14'(bfs_pkg::N_UV)};
	logic [bfs_pkg::NQ-1:0] q_raw, q_en, qual;
	logic [13:0] q_lim [0:bfs_pkg::NQ-1];
	logic [13:0] q_cnt_reg [0:bfs_pkg::NQ-1];
	assign q_raw = {cln_reg[bfs_pkg::S_LVS_LOW], cln_reg[bfs_pkg::S_RES_HI],
		cln_reg[bfs_pkg::S_PEAK], cln_reg[bfs_pkg::S_UV], cln_reg[bfs_pkg::S_OPEN],
		cln_reg[bfs_pkg::S_OV], cln_reg[bfs_pkg::S_BOOST], cln_reg[bfs_pkg::S_INV_LO],
		cln_reg[bfs_pkg::S_INV_HI]};
	assign q_en = {{2{phase_reg == bfs_pkg::PH_MONITOR}}, run, run, active, active,
		active, ign, active};

	genvar g;
	generate
		for (g = 0; g < bfs_pkg::NQ; g++)
		begin : g_qual
			if (g == bfs_pkg::Q_PEAK)
			begin : g_peak
				assign q_lim[g] = 14'(PEAK_CYC);
			end
			else if (g >= bfs_pkg::Q_FIL_LS)
			begin : g_fil
				assign q_lim[g] = 14'(FIL_CYC);
			end
			else
			begin : g_short
				assign q_lim[g] = LIM_SHORT[g];
			end
			always_ff @(posedge i_core_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
					q_cnt_reg[g] <= '0;
				else if (!q_en[g] || !q_raw[g])
					q_cnt_reg[g] <= '0;
				else if (q_cnt_reg[g] != q_lim[g])
					q_cnt_reg[g] <= q_cnt_reg[g] + 14'h0001;
			end
			assign qual[g] = (q_cnt_reg[g] == q_lim[g]);
		end
	endgenerate

	// ****************************************
	// Capacitive mode sampling
	// ****************************************
	logic ls_prev_reg, hs_prev_reg, slight_reg, severe_reg;
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ls_prev_reg <= 1'b0;
			hs_prev_reg <= 1'b0;
			slight_reg <= 1'b0;
			severe_reg <= 1'b0;
			o_ref_track <= 1'b0;
		end
		else
		begin
			ls_prev_reg <= i_low_side_gate;
			hs_prev_reg <= i_high_side_gate;
			o_ref_track <= i_low_side_gate;
			if (i_low_side_gate && !ls_prev_reg)
				slight_reg <= cln_reg[bfs_pkg::S_RES_REF];
			if (i_high_side_gate && !hs_prev_reg)
				severe_reg <= !cln_reg[bfs_pkg::S_RES_REF];
		end
	end

	// ****************************************
	// Up/down integrators
	// ****************************************
	logic [15:0] eol_tick_reg;
	logic [8:0] sev_tick_reg;
	logic [7:0] eol_cnt_reg, sev_cnt_reg;
	logic eol_cond, sev_on, eol_hit, sev_hit;
	assign eol_cond = slight_reg || cln_reg[bfs_pkg::S_ASYM] || cln_reg[bfs_pkg::S_RES_OPEN];
	assign sev_on = (phase_reg == bfs_pkg::PH_PREHEAT) || run;
	assign eol_hit = (eol_cnt_reg == 8'(bfs_pkg::EOL_LIM));
	assign sev_hit = (sev_cnt_reg == 8'(bfs_pkg::SEV_LIM));

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			eol_tick_reg <= '0;
			eol_cnt_reg <= '0;
		end
		else if (!run)
		begin
			eol_tick_reg <= '0;
			eol_cnt_reg <= '0;
		end
		else if (eol_tick_reg == 16'(EOL_TICK_CYC - 1))
		begin
			eol_tick_reg <= '0;
			if (eol_cond && !eol_hit)
				eol_cnt_reg <= eol_cnt_reg + 8'h01;
			else if (!eol_cond && eol_cnt_reg != 8'h00)
				eol_cnt_reg <= eol_cnt_reg - 8'h01;
		end
		else
			eol_tick_reg <= eol_tick_reg + 16'h0001;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sev_tick_reg <= '0;
			sev_cnt_reg <= '0;
		end
		else if (!sev_on)
		begin
			sev_tick_reg <= '0;
			sev_cnt_reg <= '0;
		end
		else if (sev_tick_reg == 9'(bfs_pkg::N_SEV_TICK - 1))
		begin
			sev_tick_reg <= '0;
			if (severe_reg && !sev_hit)
				sev_cnt_reg <= sev_cnt_reg + 8'h01;
			else if (!severe_reg && sev_cnt_reg != 8'h00)
				sev_cnt_reg <= sev_cnt_reg - 8'h01;
		end
		else
			sev_tick_reg <= sev_tick_reg + 9'h001;
	end

	// ****************************************
	// Ignition window and early overvoltage
	// ****************************************
	logic [21:0] ign_cnt_reg;
	logic [10:0] up_cnt_reg;
	logic ign_timeout, ov_early;
	assign ign_timeout = ign && (ign_cnt_reg == 22'(IGN_CYC)) && !i_run_freq_reached;
	assign ov_early = (phase_reg == bfs_pkg::PH_SOFTSTART)
		&& (up_cnt_reg < 11'(bfs_pkg::N_OV_EARLY)) && cln_reg[bfs_pkg::S_OV];

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			ign_cnt_reg <= '0;
		else if (!ign)
			ign_cnt_reg <= '0;
		else if (ign_cnt_reg != 22'(IGN_CYC))
			ign_cnt_reg <= ign_cnt_reg + 22'h000001;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			up_cnt_reg <= '0;
		else if (phase_reg != bfs_pkg::PH_SOFTSTART)
			up_cnt_reg <= '0;
		else if (up_cnt_reg != 11'(bfs_pkg::N_OV_EARLY))
			up_cnt_reg <= up_cnt_reg + 11'h001;
	end

	// ****************************************
	// Fault decisions
	// ****************************************
	logic latch_set, unlatched_off;
	logic [bfs_pkg::NC-1:0] cause_set;
	assign cause_set[bfs_pkg::C_INV] = active && qual[bfs_pkg::Q_INV_HI];
	assign cause_set[bfs_pkg::C_INTEG] = run && eol_hit;
	assign cause_set[bfs_pkg::C_SEV] = sev_on && sev_hit;
	assign cause_set[bfs_pkg::C_IGN] = ign_timeout;
	assign cause_set[bfs_pkg::C_PEAK] = run && qual[bfs_pkg::Q_PEAK];
	assign latch_set = |cause_set;
	assign unlatched_off = (active && qual[bfs_pkg::Q_OPEN])
		|| (run && qual[bfs_pkg::Q_UV])
		|| ov_early;

	// ****************************************
	// Restart capacitor settling and lamp removal
	// ****************************************
	logic [15:0] res_tmr_reg;
	logic [5:0] settle_reg;
	logic removed_reg, settled, clear_ok, in_fault;
	assign in_fault = (phase_reg == bfs_pkg::PH_FAULT);
	assign settled = (settle_reg == 6'(bfs_pkg::SETTLE_CYCLES));
	assign clear_ok = in_fault && settled && removed_reg && cln_reg[bfs_pkg::S_RES_LO];

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			res_tmr_reg <= '0;
			settle_reg <= '0;
			o_res_discharge <= 1'b0;
			removed_reg <= 1'b0;
		end
		else if (!in_fault)
		begin
			res_tmr_reg <= '0;
			settle_reg <= '0;
			o_res_discharge <= 1'b0;
			removed_reg <= 1'b0;
		end
		else if (!settled)
		begin
			if (res_tmr_reg == 16'(RES_HALF_CYC - 1))
			begin
				res_tmr_reg <= '0;
				o_res_discharge <= !o_res_discharge;
				if (o_res_discharge)
					settle_reg <= settle_reg + 6'h01;
			end
			else
				res_tmr_reg <= res_tmr_reg + 16'h0001;
		end
		else if (cln_reg[bfs_pkg::S_RES_HI])
			removed_reg <= 1'b1;
	end

	// ****************************************
	// Phase machine
	// ****************************************
	logic wait_hys_reg, ctrl_en;
	always_comb
	begin
		phase_next = phase_reg;
		case (phase_reg)
			bfs_pkg::PH_LOCKOUT:
				if (cln_reg[bfs_pkg::S_SUP_START] && ctrl_en && !wait_hys_reg)
					phase_next = bfs_pkg::PH_MONITOR;
			bfs_pkg::PH_MONITOR:
				if (i_phase_step && !qual[bfs_pkg::Q_FIL_LS] && !qual[bfs_pkg::Q_FIL_HS]
					&& !cln_reg[bfs_pkg::S_OPEN])
					phase_next = bfs_pkg::PH_SOFTSTART;
			bfs_pkg::PH_SOFTSTART:
				if (i_phase_step)
					phase_next = bfs_pkg::PH_PREHEAT;
			bfs_pkg::PH_PREHEAT:
				if (i_phase_step)
					phase_next = bfs_pkg::PH_IGNITION;
			bfs_pkg::PH_IGNITION:
				if (i_run_freq_reached)
					phase_next = bfs_pkg::PH_PRERUN;
			bfs_pkg::PH_PRERUN:
				if (i_phase_step)
					phase_next = bfs_pkg::PH_RUN;
			bfs_pkg::PH_RUN:
				phase_next = bfs_pkg::PH_RUN;
			bfs_pkg::PH_FAULT:
				if (clear_ok)
					phase_next = bfs_pkg::PH_MONITOR;
			default:
				phase_next = bfs_pkg::PH_LOCKOUT;
		endcase
		if (!sup_ok)
			phase_next = bfs_pkg::PH_LOCKOUT;
		else if (latch_set)
			phase_next = bfs_pkg::PH_FAULT;
		else if (unlatched_off)
			phase_next = bfs_pkg::PH_LOCKOUT;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			phase_reg <= bfs_pkg::PH_LOCKOUT;
		else
			phase_reg <= phase_next;
	end

	// Restart after unlatched shutdown waits for a full supply cycle
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			wait_hys_reg <= 1'b0;
		else if (!sup_ok)
			wait_hys_reg <= 1'b0;
		else if (unlatched_off)
			wait_hys_reg <= 1'b1;
	end

	// ****************************************
	// Drive outputs
	// ****************************************
	logic inv_lo_prev_reg;
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_gate_enable <= 1'b0;
			o_low_power <= 1'b1;
			o_phase <= bfs_pkg::PH_LOCKOUT;
			o_boost_pulse_end <= 1'b0;
			o_freq_step_up <= 1'b0;
			inv_lo_prev_reg <= 1'b0;
		end
		else
		begin
			o_gate_enable <= (phase_next == bfs_pkg::PH_SOFTSTART)
				|| (phase_next == bfs_pkg::PH_PREHEAT) || (phase_next == bfs_pkg::PH_IGNITION)
				|| (phase_next == bfs_pkg::PH_PRERUN) || (phase_next == bfs_pkg::PH_RUN);
			o_low_power <= (phase_next == bfs_pkg::PH_FAULT)
				|| (phase_next == bfs_pkg::PH_LOCKOUT);
			o_phase <= phase_next;
			o_boost_pulse_end <= active && qual[bfs_pkg::Q_BOOST];
			inv_lo_prev_reg <= qual[bfs_pkg::Q_INV_LO];
			o_freq_step_up <= qual[bfs_pkg::Q_INV_LO] && !inv_lo_prev_reg;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_boost_block <= 1'b0;
		else if (active && qual[bfs_pkg::Q_OV])
			o_boost_block <= 1'b1;
		else if (cln_reg[bfs_pkg::S_REC] || !active)
			o_boost_block <= 1'b0;
	end

	// ****************************************
	// Fault cause latch
	// ****************************************
	logic [bfs_pkg::NC-1:0] cause_reg;
	assign o_fault_latched = in_fault;
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cause_reg <= '0;
		else if (!sup_ok || clear_ok)
			cause_reg <= '0;
		else if (!in_fault)
			cause_reg <= cause_set;
	end

	// ****************************************
	// Register port
	// ****************************************
	logic [31:0] ctrl_reg;
	assign ctrl_en = ctrl_reg[bfs_pkg::CTRL_EN_BIT];
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			ctrl_reg <= bfs_pkg::CTRL_RESET;
		else if (i_wr && i_addr == bfs_pkg::REG_CTRL)
			ctrl_reg <= {31'h0, i_wdata[bfs_pkg::CTRL_EN_BIT]};
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_rdata <= '0;
		else if (!i_rd)
			o_rdata <= '0;
		else
			case (i_addr)
				bfs_pkg::REG_CTRL: o_rdata <= ctrl_reg;
				bfs_pkg::REG_STATUS: o_rdata <= {22'h0, wait_hys_reg, o_boost_block, phase_reg};
				bfs_pkg::REG_CAUSE: o_rdata <= {27'h0, cause_reg};
				default: o_rdata <= '0;
			endcase
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_fault_exit;
		in_fault ##1 (phase_reg == bfs_pkg::PH_MONITOR);
	endsequence

	a_fault_gates_off: assert property (in_fault |-> !o_gate_enable && o_low_power)
		else $error("gates on in fault phase");
	a_inv_hi_latch: assert property (sup_ok && cause_set[bfs_pkg::C_INV] |=> in_fault)
		else $error("inverter overcurrent did not latch");
	a_sev_cap_fault: assert property (sup_ok && sev_on && sev_hit |=> in_fault)
		else $error("severe capacitive count did not latch");
	a_ign_window: assert property (ign && !i_run_freq_reached && sup_ok
		&& ign_cnt_reg == 22'(IGN_CYC) |=> in_fault)
		else $error("ignition window expiry missed");
	a_uv_unlatched: assert property (sup_ok && run && qual[bfs_pkg::Q_UV] && !latch_set
		|=> phase_reg == bfs_pkg::PH_LOCKOUT && wait_hys_reg)
		else $error("bus undervoltage not handled");
	a_lockout_reset: assert property (!sup_ok |=> phase_reg == bfs_pkg::PH_LOCKOUT
		##1 cause_reg == '0)
		else $error("supply drop did not reset latch");
	a_boost_block: assert property (active && qual[bfs_pkg::Q_OV] |=> o_boost_block)
		else $error("boost not blocked on overvoltage");
	a_freq_step: assert property ($rose(qual[bfs_pkg::Q_INV_LO]) |=> o_freq_step_up ##1
		!o_freq_step_up)
		else $error("frequency step pulse wrong");
	a_settle_first: assert property (s_fault_exit |-> $past(settled) && $past(removed_reg))
		else $error("fault cleared before settling");
endmodule : bfs_supervisor
